// ### src/eep_pkg.sv
// Shared constants and types for the two-wire serial EEPROM slave.
// Assumes a 20 MHz system clock; all bus pins are asynchronous to it.
package eep_pkg;
    // System clock rate in hertz.
    localparam int CLK_HZ = 20_000_000;
    // Longest program cycle, in milliseconds.
    localparam int PROG_TIME_MS = 5;
    // Power-up delay before reads and writes, in milliseconds.
    localparam int PU_TIME_MS = 1;
    // Longest times round down to whole cycles.
    localparam int PROG_CYC = PROG_TIME_MS * (CLK_HZ / 1000);
    localparam int PU_CYC = PU_TIME_MS * (CLK_HZ / 1000);
    // Word address width and page geometry.
    localparam int ADDR_W = 8;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    // Depth of the write data FIFO.
    localparam int FIFO_DEPTH = 8;
    // Bit counter value once a whole byte has passed.
    localparam logic [3:0] BIT_LAST = 4'h8;
    // Reset value of byte-wide registers.
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Synchroniser reset: lines idle high (bit 0 clock, bit 1 data).
    localparam logic [5:0] PIN_RST = 6'h03;
    // Commit index value meaning no commit in progress.
    localparam logic [4:0] IDX_DONE = 5'h10;
    // Device type code; this value is arbitrary.
    localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;
    // Bus-side states of the slave; nine states need four bits.
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_WADDR, ST_WACK, ST_WDATA, ST_RDATA, ST_RACK, ST_WAIT
    } eep_bus_e;
endpackage

// ### src/eep_strm_if.sv
// Valid/ready stream carrier between the slave and its write FIFO.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface eep_strm_if #(parameter int W = 16) ();
    logic valid; // Producer has a word.
    logic ready; // Consumer takes it.
    logic [W-1:0] data; // The word.
    modport prod (output valid, output data, input ready);
    modport cons (input valid, input data, output ready);
endinterface // eep_strm_if

// ### src/eep_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/10ps
module eep_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
)(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    eep_strm_if.cons s_in,
    eep_strm_if.prod s_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH]; // Storage, no reset needed.
    logic [AW:0] wr_ptr_ff; // Extra bit tells full from empty.
    logic [AW:0] rd_ptr_ff;
    logic full;
    logic empty;
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign s_in.ready = ~full;
    assign s_out.valid = ~empty;
    assign s_out.data = mem_ff[rd_ptr_ff[AW-1:0]];

    // Pointers move only on accepted handshakes.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (s_in.valid && !full)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (s_out.ready && !empty)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // Storage write.
    always_ff @(posedge i_clk_sys)
    begin
        if (s_in.valid && !full)
            mem_ff[wr_ptr_ff[AW-1:0]] <= s_in.data;
    end
endmodule // eep_fifo

// ### src/eep_mem.sv
// Nonvolatile array model: one write port, registered read port.
// Assumes the caller holds the read address steady before use.
`timescale 1ns/10ps
module eep_mem #(
    parameter int AW = 8,
    parameter int DW = 8
)(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] arr_ff [2**AW]; // Array cells.

    // Write port.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_we)
            arr_ff[i_waddr] <= i_wdata;
    end

    // Read data always comes out of a register, one cycle late.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            o_rdata <= '0;
        else
            o_rdata <= arr_ff[i_raddr];
    end
endmodule // eep_mem

// ### src/eep_i2c_slave.sv
// Two-wire serial EEPROM slave front end with page buffer and array.
// Assumes SCL, SDA, WP and straps are asynchronous pins; the bench
// resolves the open-drain SDA wire from o_sda_oe_n and the master's pull.
// Overview of operation
// - Program cycle ends within five milliseconds.
// - Busy device releases SDA, never acknowledges.
// - Device is slave only; master clocks.
// - SDA is open drain: low or released.
// - Write-protect high blocks all programming.
// - SDA change with SCL high is START/STOP.
// - START is SDA falling, SCL high.
// - STOP is SDA rising, SCL high.
// - Address byte: type code plus three straps.
// - Address LSB one reads, zero writes.
// - Receiver acknowledges each byte on ninth clock.
// - Acknowledge matching address and written bytes.
// - Read: send byte, stop on missing acknowledge.
// - Byte write loads pointer, programs at STOP.
// - Page write takes up to sixteen bytes.
// - Only low address bits advance per byte.
// - Extra bytes wrap and overwrite within page.
// - All buffered bytes program in one cycle.
// - Address poll gets acknowledge only when idle.
// - Pointer holds last accessed address plus one.
// - Sequential reads advance all address bits.
`timescale 1ns/10ps
module eep_i2c_slave
    import eep_pkg::*;
#(
    parameter int PROG_CYC_P = PROG_CYC,
    parameter int PU_CYC_P = PU_CYC,
    parameter logic [3:0] DEV_TYPE = DEV_TYPE_DFLT
)(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_wp,
    input wire logic [2:0] i_chip_select_straps,
    output logic o_sda_o,
    output logic o_sda_oe_n,
    output logic o_prog_busy
);
    localparam int CNT_W = $clog2(PROG_CYC_P + 1);
    localparam int PU_W = $clog2(PU_CYC_P + 1);
    localparam int FW = ADDR_W + 8;

    logic [5:0] pin_s1_ff; // First stage, read only by the second.
    logic [5:0] pin_s2_ff;
    logic [5:0] pin_s3_ff;
    logic [5:0] pin_flt_ff; // Accepted pin levels.
    logic scl_q_ff; // Previous accepted clock level.
    logic sda_q_ff; // Previous accepted data level.
    logic scl_f, sda_f, wp_f;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic [PU_W-1:0] pu_cnt_ff; // Power-up hold-off counter.
    logic pu_done;
    eep_bus_e st_ff; // Bus state.
    logic [3:0] bit_cnt_ff; // Clock rises seen in this byte.
    logic [7:0] shreg_ff; // Received bits.
    logic [7:0] tx_ff; // Byte being sent.
    logic sda_drv_ff; // High while pulling SDA low.
    logic rw_ff; // Direction from the address byte.
    logic [ADDR_W-1:0] ptr_ff; // Address counter.
    logic [ADDR_W-1:0] ptr_pg_nxt; // Pointer with page-local increment.
    logic wrote_ff; // Data bytes taken since last STOP.
    logic addr_match;
    logic [CNT_W-1:0] prog_cnt_ff; // Program cycle countdown.
    logic busy;
    logic prog_go, prog_discard;
    logic [4:0] idx_ff; // Page entry being committed.
    logic [7:0] pg_data_ff [PAGE_BYTES]; // Page buffer.
    logic [PAGE_BYTES-1:0] pg_vld_ff; // Entries holding new data.
    logic [ADDR_W-PAGE_W-1:0] pg_hi_ff; // Page number of the buffer.
    logic drain;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [CNT_W-1:0] busy_len_ff; // Helper for checking.

    eep_strm_if #(.W(FW)) wr_in ();
    eep_strm_if #(.W(FW)) wr_out ();

    // Pins pass three flops; a level counts once stages two and
    // three agree, which also rejects single-sample glitches.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pin_s1_ff <= PIN_RST;
            pin_s2_ff <= PIN_RST;
            pin_s3_ff <= PIN_RST;
            pin_flt_ff <= PIN_RST;
        end
        else
        begin
            pin_s1_ff <= {i_wp, i_chip_select_straps, i_sda, i_scl};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_flt_ff <= (pin_s2_ff & pin_s3_ff) | (pin_flt_ff & (pin_s2_ff | pin_s3_ff));
        end
    end

    assign scl_f = pin_flt_ff[0];
    assign sda_f = pin_flt_ff[1];
    assign wp_f = pin_flt_ff[5];

    // Previous levels for edge finding.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end
        else
        begin
            scl_q_ff <= scl_f;
            sda_q_ff <= sda_f;
        end
    end

    // Data moving while the clock is high marks a frame edge.
    assign scl_rise = scl_f & ~scl_q_ff;
    assign scl_fall = ~scl_f & scl_q_ff;
    assign start_ev = pu_done & scl_f & scl_q_ff & sda_q_ff & ~sda_f;
    assign stop_ev = pu_done & scl_f & scl_q_ff & ~sda_q_ff & sda_f;

    // The bus is ignored until the power-up delay has run out.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            pu_cnt_ff <= PU_W'(PU_CYC_P);
        else if (!pu_done)
            pu_cnt_ff <= pu_cnt_ff - 1'b1;
    end
    assign pu_done = (pu_cnt_ff == '0);

    // Only type code plus strap match selects us; busy hides us.
    assign addr_match = (shreg_ff[7:1] == {DEV_TYPE, pin_flt_ff[4:2]});
    assign ptr_pg_nxt = {ptr_ff[ADDR_W-1:PAGE_W], ptr_ff[PAGE_W-1:0] + 1'b1};

    // Write data goes to the FIFO with its word address.
    assign wr_in.valid = (st_ff == ST_WDATA) && scl_fall && (bit_cnt_ff == BIT_LAST);
    assign wr_in.data = {ptr_ff, shreg_ff};

    // Bus state machine. STOP beats START beats bit handling; the
    // clock is only ever sampled, never driven.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            st_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shreg_ff <= RST_BYTE;
            tx_ff <= RST_BYTE;
            sda_drv_ff <= 1'b0;
            rw_ff <= 1'b0;
            ptr_ff <= '0;
            wrote_ff <= 1'b0;
        end
        else if (stop_ev)
        begin
            // Frame over; SDA is let go.
            st_ff <= ST_IDLE;
            sda_drv_ff <= 1'b0;
            wrote_ff <= 1'b0;
        end
        else if (start_ev)
        begin
            // Also a repeated START inside a frame.
            st_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_drv_ff <= 1'b0;
        end
        else
        begin
            if (scl_rise)
            begin
                // Data is taken on the rising clock.
                shreg_ff <= {shreg_ff[6:0], sda_f};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            case (st_ff)
                ST_ADDR:
                begin
                    if (scl_fall && bit_cnt_ff == BIT_LAST)
                    begin
                        if (addr_match && !busy)
                        begin
                            sda_drv_ff <= 1'b1;
                            rw_ff <= shreg_ff[0];
                            st_ff <= ST_AACK;
                        end
                        else
                            st_ff <= ST_WAIT;
                    end
                end
                ST_AACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_ff <= 4'h0;
                        if (rw_ff)
                        begin
                            // Read starts at the pointer, no new address.
                            tx_ff <= mem_rdata;
                            sda_drv_ff <= ~mem_rdata[7];
                            st_ff <= ST_RDATA;
                        end
                        else
                        begin
                            sda_drv_ff <= 1'b0;
                            st_ff <= ST_WADDR;
                        end
                    end
                end
                ST_WADDR:
                begin
                    if (scl_fall && bit_cnt_ff == BIT_LAST)
                    begin
                        ptr_ff <= shreg_ff;
                        sda_drv_ff <= 1'b1;
                        st_ff <= ST_WACK;
                    end
                end
                ST_WACK:
                begin
                    // Shared acknowledge slot for address and data bytes.
                    if (scl_fall)
                    begin
                        sda_drv_ff <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        st_ff <= ST_WDATA;
                    end
                end
                ST_WDATA:
                begin
                    if (scl_fall && bit_cnt_ff == BIT_LAST)
                    begin
                        if (wr_in.ready)
                        begin
                            // Low bits wrap, so byte 17 lands on byte 1.
                            ptr_ff <= ptr_pg_nxt;
                            wrote_ff <= 1'b1;
                            sda_drv_ff <= 1'b1;
                            st_ff <= ST_WACK;
                        end
                        else
                            st_ff <= ST_WAIT; // A full FIFO refuses the byte.
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_ff == BIT_LAST)
                        begin
                            // Release for the master's acknowledge.
                            sda_drv_ff <= 1'b0;
                            ptr_ff <= ptr_ff + 1'b1;
                            st_ff <= ST_RACK;
                        end
                        else
                        begin
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            sda_drv_ff <= ~tx_ff[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise && sda_f)
                        st_ff <= ST_WAIT;
                    else if (scl_fall)
                    begin
                        bit_cnt_ff <= 4'h0;
                        tx_ff <= mem_rdata;
                        sda_drv_ff <= ~mem_rdata[7];
                        st_ff <= ST_RDATA;
                    end
                end
                ST_IDLE, ST_WAIT:
                begin
                    // Nothing until the next START or STOP.
                end
                default:
                    st_ff <= ST_IDLE;
            endcase
        end
    end

    // Only ever pull low or release; the wire is shared.
    assign o_sda_o = 1'b0;
    assign o_sda_oe_n = ~sda_drv_ff;

    // A STOP after written bytes starts the program cycle unless
    // write protect is high, in which case the page is dropped.
    assign prog_go = stop_ev && wrote_ff && !wp_f && !busy;
    assign prog_discard = stop_ev && wrote_ff && wp_f;

    // Program cycle timer; length is a parameter for short sims.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            prog_cnt_ff <= '0;
        else if (prog_go)
            prog_cnt_ff <= CNT_W'(PROG_CYC_P);
        else if (busy)
            prog_cnt_ff <= prog_cnt_ff - 1'b1;
    end
    assign busy = (prog_cnt_ff != '0);
    assign o_prog_busy = busy;

    // Commit walks all page entries early in the program cycle.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            idx_ff <= IDX_DONE;
        else if (prog_go)
            idx_ff <= 5'h00;
        else if (!idx_ff[4])
            idx_ff <= idx_ff + 5'h01;
    end
    assign mem_we = !idx_ff[4] && pg_vld_ff[idx_ff[3:0]];

    // The FIFO drains into the page buffer; it stalls while busy.
    assign drain = wr_out.valid && wr_out.ready;
    assign wr_out.ready = ~busy;

    // Page number follows the newest byte; all share one page.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            pg_hi_ff <= '0;
        else if (drain)
            pg_hi_ff <= wr_out.data[FW-1:8+PAGE_W];
    end

    // One page entry per generate step; a later byte for the same
    // slot simply replaces the earlier one.
    for (genvar i = 0; i < PAGE_BYTES; i++)
    begin : g_page
        always_ff @(posedge i_clk_sys)
        begin
            if (i_rst)
            begin
                pg_vld_ff[i] <= 1'b0;
                pg_data_ff[i] <= RST_BYTE;
            end
            else if (drain && wr_out.data[8+PAGE_W-1:8] == PAGE_W'(i))
            begin
                pg_vld_ff[i] <= 1'b1;
                pg_data_ff[i] <= wr_out.data[7:0];
            end
            else if (prog_discard || (mem_we && idx_ff[3:0] == PAGE_W'(i)))
                pg_vld_ff[i] <= 1'b0;
        end
    end

    eep_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .s_in(wr_in.cons),
        .s_out(wr_out.prod)
    );

    eep_mem #(.AW(ADDR_W), .DW(8)) u_mem (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_we(mem_we),
        .i_waddr({pg_hi_ff, idx_ff[3:0]}),
        .i_wdata(pg_data_ff[idx_ff[3:0]]),
        .i_raddr(ptr_ff),
        .o_rdata(mem_rdata)
    );

    // Helper: length of the current busy stretch.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !busy)
            busy_len_ff <= '0;
        else
            busy_len_ff <= busy_len_ff + 1'b1;
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_addr_end;
        st_ff == ST_ADDR && scl_fall && bit_cnt_ff == BIT_LAST;
    endsequence
    sequence s_rd_end;
        st_ff == ST_RDATA && scl_fall && bit_cnt_ff == BIT_LAST;
    endsequence

    a_prog_len: assert property ($fell(busy) |-> busy_len_ff == CNT_W'(PROG_CYC_P))
        else $error("program cycle length wrong");
    a_busy_release: assert property (busy |-> o_sda_oe_n && !o_sda_o)
        else $error("SDA driven while busy");
    a_busy_no_ack: assert property (s_addr_end ##0 busy |=> st_ff == ST_WAIT && !sda_drv_ff)
        else $error("address acknowledged while busy");
    a_addr_ack: assert property (s_addr_end ##0 (addr_match && !busy) |=> st_ff == ST_AACK ##0 !o_sda_oe_n)
        else $error("matching address not acknowledged");
    a_start_addr: assert property (start_ev |=> st_ff == ST_ADDR && bit_cnt_ff == 4'h0)
        else $error("START not taken");
    a_stop_idle: assert property (stop_ev |=> st_ff == ST_IDLE && o_sda_oe_n)
        else $error("STOP not taken");
    a_wp_block: assert property (stop_ev && wp_f && !busy |=> !busy [*2])
        else $error("program started under write protect");
    a_page_wrap: assert property (wr_in.valid && wr_in.ready |=> ptr_ff == $past(ptr_pg_nxt))
        else $error("page pointer step wrong");
    a_read_inc: assert property (s_rd_end |=> st_ff == ST_RACK && ptr_ff == $past(ptr_ff) + 8'h01)
        else $error("read pointer step wrong");
    a_rw_select: assert property (st_ff == ST_AACK && scl_fall && rw_ff |=> st_ff == ST_RDATA)
        else $error("read not entered");
    a_read_nack: assert property (st_ff == ST_RACK && scl_rise && sda_f |=> st_ff == ST_WAIT)
        else $error("sending after missing acknowledge");
endmodule // eep_i2c_slave

// ### test/eep_mst.sv
// Two-wire bus master model: drives SCL and pulls SDA low on demand.
// Assumes a pull-up on the SDA wire, which the bench resolves.
`timescale 1ns/10ps
module eep_mst (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    // The low phase is stretched because the slave answers several system cycles late.
    localparam int T_Q = 300;
    // Both lines start released.
    initial
    begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // Only this model clocks and frames the bus; it also serves as a repeated start.
    task automatic start();
        #T_Q o_sda_pull = 1'b0;
        #T_Q o_scl = 1'b1;
        #T_Q o_sda_pull = 1'b1;
        #T_Q o_scl = 1'b0;
    endtask
    // Every frame ends here, and the bus is left idle before anything new.
    task automatic stop();
        #T_Q o_sda_pull = 1'b1;
        #T_Q o_scl = 1'b1;
        #T_Q o_sda_pull = 1'b0;
        #T_Q;
    endtask
    // One clock: data moves mid low phase and holds through the high phase.
    task automatic bit_io(input logic b, output logic s);
        #T_Q o_sda_pull = !b;
        #T_Q o_scl = 1'b1;
        #100 s = i_sda;
        #100 o_scl = 1'b0;
    endtask
    // Byte out MSB first; the flag returned is high on acknowledge.
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // Byte in MSB first, then our acknowledge or its absence.
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(!ack, s);
    endtask
endmodule // eep_mst

// ### test/i2c_eeprom_slave_interface_bench.sv
// Bench for the two-wire EEPROM slave with a master model and a pull-up.
// Assumes shortened program and power-up counts handed in as parameters.
`timescale 1ns/10ps
module i2c_eeprom_slave_interface_bench;
    localparam int PROG = 300; // Short program cycle keeps the run brief.
    localparam int PU = 20; // Short power-up hold-off.
    logic clk, rst, wp, sda_pull, scl, sda_o, sda_oe_n, busy, sda;
    logic [2:0] straps;
    int fail_count = 0;
    int samples_checked = 0;
    int busy_cyc = 0; // Cycles seen with the program cycle running.
    // Open-drain wire with pull-up: low whenever anyone pulls it.
    assign sda = (!sda_oe_n || sda_pull) ? 1'b0 : 1'b1;
    eep_i2c_slave #(.PROG_CYC_P(PROG), .PU_CYC_P(PU)) eep_i2c_slave_i (
        .i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .i_wp(wp),
        .i_chip_select_straps(straps), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
        .o_prog_busy(busy));
    eep_mst eep_mst_i (.i_sda(sda), .o_scl(scl), .o_sda_pull(sda_pull));
    // System clock.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Count program-cycle length.
    always @(posedge clk)
        if (busy === 1'b1)
            busy_cyc++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ack_is(input logic a, input logic e);
        check({15'h0000, a}, {15'h0000, e});
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Slave address byte for our straps.
    function automatic logic [7:0] sa(input logic rw);
        return {eep_pkg::DEV_TYPE_DFLT, 3'h3, rw};
    endfunction
    // Write n bytes counting up from d0 at word address wa, then STOP.
    task automatic wr(input logic [7:0] wa, input int n, input logic [7:0] d0);
        logic a;
        eep_mst_i.start();
        eep_mst_i.send(sa(1'b0), a);
        ack_is(a, 1'b1);
        eep_mst_i.send(wa, a);
        ack_is(a, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            eep_mst_i.send(d0 + i[7:0], a);
            ack_is(a, 1'b1);
        end
        eep_mst_i.stop();
    endtask
    // Optional dummy write of wa, then read the expected bytes, NACK on the last.
    task automatic rd(input logic sel, input logic [7:0] wa, input logic [7:0] exp[$]);
        logic a;
        logic [7:0] d;
        if (sel)
        begin
            eep_mst_i.start();
            eep_mst_i.send(sa(1'b0), a);
            eep_mst_i.send(wa, a);
        end
        eep_mst_i.start();
        eep_mst_i.send(sa(1'b1), a);
        ack_is(a, 1'b1);
        foreach (exp[i])
        begin
            eep_mst_i.recv(i < exp.size() - 1, d);
            check({8'h00, d}, {8'h00, exp[i]});
        end
        eep_mst_i.stop();
    endtask
    // Bounded wait for the program cycle to end; running out counts as a mismatch.
    task automatic wait_idle();
        for (int k = 0; k < 1000 && busy !== 1'b0; k++)
            @(negedge clk);
        ack_is(busy, 1'b0);
    endtask
    // Foreign straps draw no acknowledge.
    task automatic t_bad_addr();
        logic a;
        eep_mst_i.start();
        eep_mst_i.send({eep_pkg::DEV_TYPE_DFLT, 3'h4, 1'b0}, a);
        ack_is(a, 1'b0);
        eep_mst_i.stop();
    endtask
    // Eighteen bytes from 0x3E wrap in the page and overwrite the first two.
    task automatic t_page();
        logic [7:0] q[$];
        wr(8'h3E, 18, 8'h10);
        wait_idle();
        for (int k = 0; k < 15; k++)
            q.push_back(8'h12 + k[7:0]);
        rd(1'b1, 8'h30, q);
        rd(1'b0, 8'h00, {8'h21});
    endtask
    // Byte write: poll refused while busy, exact busy length, read across a page.
    task automatic t_byte();
        logic a;
        busy_cyc = 0;
        wr(8'h40, 1, 8'h5A);
        eep_mst_i.start();
        eep_mst_i.send(sa(1'b0), a);
        ack_is(a, 1'b0);
        ack_is(busy, 1'b1);
        eep_mst_i.stop();
        wait_idle();
        check(busy_cyc[15:0], PROG[15:0]);
        eep_mst_i.start();
        eep_mst_i.send(sa(1'b0), a);
        ack_is(a, 1'b1);
        eep_mst_i.stop();
        rd(1'b1, 8'h3F, {8'h21, 8'h5A});
    endtask
    // A protected write is acknowledged but never programmed.
    task automatic t_wp();
        wp = 1'b1;
        busy_cyc = 0;
        wr(8'h31, 1, 8'hEE);
        repeat (20) @(negedge clk);
        check(busy_cyc[15:0], 16'h0000);
        wp = 1'b0;
        rd(1'b1, 8'h31, {8'h13});
    endtask
    // Main sequence: reset, power-up hold-off, then the scenarios.
    initial
    begin
        rst = 1'b1;
        wp = 1'b0;
        straps = 3'h3;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (PU + 5) @(negedge clk);
        t_bad_addr();
        t_page();
        t_byte();
        t_wp();
        ack_is(sda_o, 1'b0);
        tally_and_finish();
    end
    // Watchdog well above the expected run of about half a millisecond.
    initial
    begin
        #3_000_000;
        fail_count++;
        tally_and_finish();
    end
endmodule // i2c_eeprom_slave_interface_bench
